// ==== src/sfr_page_params.svh ====
`ifndef SFR_PAGE_PARAMS_SVH
`define SFR_PAGE_PARAMS_SVH
// Register locations in the special-register space
`define PAGE_SELECT_ADDR   8'ha7
`define XRAM_PAGE_ADDR     8'haa
`define SFR_SPACE_BASE     8'h80
// Page codes and reset values
`define PAGE_ZERO          8'h00
`define PAGE_EXTRA         8'h0f
`define PAGE_SELECT_RESET  8'h00
`define XRAM_PAGE_RESET    4'h0
// Field layout of the XRAM page register
`define XRAM_FIELD_MSB     3
`define XRAM_UNUSED_READ   4'h0
`endif

// ==== src/sfr_page_pkg.sv ====
package sfr_page_pkg;
    // One direct access from the core
    typedef struct packed {
        logic       valid;
        logic       write;
        logic       bit_op;
        logic [2:0] bit_pos;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_s;
    // Where a decoded access goes
    typedef enum logic [3:0] {
        TGT_NONE    = 4'b0001,
        TGT_PAGE    = 4'b0010,
        TGT_XRAM    = 4'b0100,
        TGT_PERIPH  = 4'b1000
    } target_e;
endpackage

// ==== src/sfr_paging.sv ====
// Notes on behaviour
// R1 - Upper four XRAM page bits read zero
// R2 - 8-bit external move high byte from page
// R3 - High byte is zero nibble plus field
// R4 - XRAM page register only on page zero
// R5 - Direct 0x80-0xFF goes to special registers
// R6 - Bit access only where low nibble 0/8
// R7 - Software avoids reserved special locations
// R8 - Page zero selected out of reset
// R9 - Core registers decoded on both pages
// R10 - Same address maps by page
// R11 - Software guards page 0xF with interrupts off
// R12 - Low byte from R0 or R1
// R13 - Page register at A7, all pages
// R14 - Page write affects next instruction
`include "sfr_page_params.svh"

// Timing: every result is registered, so the core sees the answer
// of an access one enabled clock after it presents the request.
// A peripheral read value must be valid in the cycle of the request;
// the peripheral address is only registered for the following cycle.
// Hazard: the page register changes only at an instruction boundary,
// so a read-modify-write of it never splits across two pages.
// Limitation: reserved locations are passed on to the peripherals
// as ordinary accesses; nothing here flags them.
// Limitation: bit accesses to the page and XRAM page registers are
// refused, as neither sits on a bit-addressable column.
// Trade-off: the page write is held in a pending register rather
// than applied at once, costing nine flops but keeping the page of
// an access fixed for the whole instruction.
// Shared core registers report page zero to the peripherals, so one
// decoder there serves both pages for them.

module sfr_paging (
    // Clock and control
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 clk_en,
    // Direct access from the core
    input  wire sfr_page_pkg::sfr_req_s req,
    input  wire logic                 indirect,
    input  wire logic                 instr_done,
    input  wire logic [7:0]           periph_rdata,
    // External move request
    input  wire logic                 xmove_short,
    input  wire logic [7:0]           index_reg,
    input  wire logic [15:0]          dptr,
    // Results
    output logic [7:0]                rdata,
    output logic                      sfr_hit,
    output logic                      bit_refused,
    output logic [7:0]                periph_addr,
    output logic [7:0]                periph_page,
    output logic                      periph_sel,
    output logic [15:0]               xram_addr,
    output logic [7:0]                page_select_q
);
    import sfr_page_pkg::*;

    // Core registers that answer on every page
    function automatic logic shared_reg(input logic [7:0] a);
        unique case (a)
            8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h90, 8'ha0,
            8'ha7, 8'ha8, 8'ha9, 8'hd0, 8'he0, 8'he6, 8'he7,
            8'hf0, 8'hf6, 8'hf7: shared_reg = 1'b1; // R9
            default: shared_reg = 1'b0;
        endcase
    endfunction

    // Bit operations are legal only on column 0 and 8
    function automatic logic bit_ok(input logic [7:0] a);
        bit_ok = (a[2:0] == 3'h0); // R6
    endfunction

    // Page register and the write that waits for the instruction boundary
    logic [7:0]  page_reg, page_next;       // Selected page for decode
    logic [7:0]  pend_reg, pend_next;       // Written page awaiting boundary
    logic        pend_v_reg, pend_v_next;   // A page write is waiting
    // XRAM page field; the upper nibble is never stored
    logic [3:0]  xpage_reg, xpage_next;
    // Next values of the registered outputs
    logic [7:0]  rdata_next, paddr_next, ppage_next;
    logic        hit_next, refused_next, psel_next;
    logic [15:0] xaddr_next;
    // Decode results of the access in this cycle
    logic        in_sfr;
    logic        wr_ok;
    target_e     tgt;
    logic [7:0]  cur_byte, new_byte, merged;

    // Decode: direct access above 0x7f is a special register
    always_comb begin
        // Indirect accesses above 0x7f reach upper data RAM, not here
        in_sfr = req.valid && !indirect && req.addr[7]; // R5
        tgt = TGT_NONE;
        if (in_sfr) begin
            if (req.addr == `PAGE_SELECT_ADDR) begin
                tgt = TGT_PAGE; // R13
            end else if (req.addr == `XRAM_PAGE_ADDR &&
                         page_reg == `PAGE_ZERO) begin
                tgt = TGT_XRAM; // R4
            end else begin
                tgt = TGT_PERIPH; // R10
            end
        end
    end

    // Read value of the local target
    always_comb begin
        // Unused upper bits of the XRAM page read as zero
        unique case (tgt)
            TGT_PAGE: cur_byte = page_reg;
            TGT_XRAM: cur_byte = {`XRAM_UNUSED_READ, xpage_reg}; // R1
            TGT_PERIPH: cur_byte = periph_rdata;
            default: cur_byte = 8'h00;
        endcase
    end

    // One lane per bit: a bit write replaces only the addressed position
    // Lanes are identical, so they are generated rather than written out
    for (genvar i = 0; i < 8; i++) begin : g_merge
        assign merged[i] = (req.bit_pos == 3'(i)) ? req.wdata[0]
                                                  : cur_byte[i];
    end
    // Read-modify-write keeps the neighbouring bits of the target
    assign new_byte = req.bit_op ? merged : req.wdata;
    // A refused bit write changes nothing
    assign wr_ok = req.valid && req.write && !refused_next;

    // Page group: a write waits so the current access keeps its page
    always_comb begin
        page_next = page_reg;
        pend_next = pend_reg;
        pend_v_next = pend_v_reg;
        // Only the page register location loads the pending value
        if (wr_ok && tgt == TGT_PAGE) begin
            pend_next = new_byte; // R14
            pend_v_next = 1'b1;
        end
        // A boundary in the same cycle as the write applies it at once
        if (instr_done && pend_v_next) begin
            page_next = pend_next; // R13 R14
            pend_v_next = 1'b0;
        end
    end

    // XRAM page group: only the low field is kept
    always_comb begin
        xpage_next = xpage_reg;
        // Written only while page zero is in force; off page the same
        // location belongs to a peripheral
        if (wr_ok && tgt == TGT_XRAM) begin
            xpage_next = new_byte[`XRAM_FIELD_MSB:0]; // R1
        end
    end

    // Output group: answer of this access, shown one cycle later
    always_comb begin
        refused_next = in_sfr && req.bit_op && !bit_ok(req.addr); // R6
        hit_next = in_sfr; // R5
        rdata_next = cur_byte;
        // Peripherals see the page in force; shared ones stay visible
        // A refused bit write reaches no peripheral
        psel_next = (tgt == TGT_PERIPH) && !refused_next;
        paddr_next = req.addr;
        ppage_next = shared_reg(req.addr) ? `PAGE_ZERO : page_reg; // R9
        // Short form: page field high, index register low
        if (xmove_short) begin
            xaddr_next = {`XRAM_UNUSED_READ, xpage_reg, // R2 R3
                          index_reg};                   // R12
        end else begin
            // Long form passes the data pointer through untouched
            xaddr_next = dptr;
        end
    end

    // Page registers; page zero out of reset, frozen while clk_en low
    always_ff @(posedge clk) begin
        if (reset) begin
            page_reg <= `PAGE_SELECT_RESET; // R8
            pend_reg <= `PAGE_SELECT_RESET;
            pend_v_reg <= 1'b0;
            page_select_q <= `PAGE_SELECT_RESET;
        end else if (clk_en) begin
            page_reg <= page_next;
            pend_reg <= pend_next;
            pend_v_reg <= pend_v_next;
            page_select_q <= page_next;
        end
    end

    // XRAM page field register
    always_ff @(posedge clk) begin
        if (reset) begin
            xpage_reg <= `XRAM_PAGE_RESET;
        end else if (clk_en) begin
            xpage_reg <= xpage_next;
        end
    end

    // Output registers; cleared on reset so no stale hit is seen
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= 8'h00;
            sfr_hit <= 1'b0;
            bit_refused <= 1'b0;
            periph_addr <= 8'h00;
            periph_page <= 8'h00;
            periph_sel <= 1'b0;
            xram_addr <= 16'h0000;
        end else if (clk_en) begin
            rdata <= rdata_next;
            sfr_hit <= hit_next;
            bit_refused <= refused_next;
            periph_addr <= paddr_next;
            periph_page <= ppage_next;
            periph_sel <= psel_next;
            xram_addr <= xaddr_next;
        end
    end
endmodule

// ==== tb/periph_model.sv ====
module periph_model (
    // Address seen, answer given in the same cycle
    input  wire logic [7:0] addr,
    output logic [7:0]      rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // Inverted address, so a stray answer never mimics a local register
    assign rdata = ~addr;
endmodule

// ==== tb/sfr_paging_chk.sv ====
module sfr_paging_chk (
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   reset,
    // Core side
    input wire sfr_page_pkg::sfr_req_s req,
    input wire logic                   indirect,
    input wire logic                   instr_done,
    input wire logic                   xmove_short,
    input wire logic [7:0]             index_reg,
    // Results
    input wire logic [7:0]             rdata,
    input wire logic                   sfr_hit,
    input wire logic                   bit_refused,
    input wire logic [7:0]             periph_page,
    input wire logic [15:0]            xram_addr,
    input wire logic [7:0]             page_select_q
);
    timeunit 1ns;
    timeprecision 1ns;
    wire dir = req.valid && !indirect && req.addr[7];
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Reset guards keep the first edge from judging reset-time inputs
    page_reset_a: assert property ($past(reset) |-> page_select_q == 8'h00)
        else $error("page not zero after reset");
    short_move_a: assert property ($past(xmove_short) && !$past(reset) |->
        xram_addr[15:12] == 4'h0 && xram_addr[7:0] == $past(index_reg))
        else $error("short move address wrong");
    sfr_hit_a: assert property (!$past(reset) |-> sfr_hit == $past(dir))
        else $error("direct access steering wrong");
    bit_ok_a: assert property ($past(dir && req.bit_op) && !$past(reset) |->
        bit_refused == ($past(req.addr[2:0]) != 3'h0))
        else $error("bit access decision wrong");
    page_hold_a: assert property (!$past(instr_done) && !$past(reset) |->
        $stable(page_select_q)) else $error("page changed mid instruction");
    page_read_a: assert property ($past(dir && !req.write && req.addr == 8'ha7)
        |-> rdata == $past(page_select_q)) else $error("page read wrong");
    xram_read_a: assert property ($past(dir && !req.write && req.addr == 8'haa
        && page_select_q == 8'h00) |-> rdata[7:4] == 4'h0)
        else $error("xram page upper bits set");
    shared_reg_a: assert property ($past(dir && req.addr == 8'he0)
        |-> periph_page == 8'h00) else $error("shared register paged");
    paged_reg_a: assert property ($past(dir && req.addr == 8'h91)
        |-> periph_page == $past(page_select_q)) else $error("page not used");
    // Main scenarios reached
    cover property (page_select_q == 8'h0f);
    cover property (bit_refused);
    cover property ($past(xmove_short) && xram_addr[11:8] == 4'h3);
endmodule
bind sfr_paging sfr_paging_chk sfr_paging_chk_i (.*);

// ==== tb/test_sfr_paging.sv ====
module test_sfr_paging;
    timeunit 1ns;
    timeprecision 1ns;
    import sfr_page_pkg::*;
    logic clk = 1'b0, reset = 1'b1, indirect = 1'b0, instr_done = 1'b0;
    logic xmove_short = 1'b0, sfr_hit, bit_refused, periph_sel;
    logic [7:0] index_reg = 8'h00, periph_rdata, rdata, periph_addr;
    logic [7:0] periph_page, page_select_q;
    logic [15:0] dptr = 16'h0000, xram_addr;
    sfr_req_s req = '0;
    int miscompares = 0, cmp_count = 0;
    always #25 clk = ~clk;
    sfr_paging sfr_paging_i (.clk_en(1'b1), .*);
    periph_model periph_model_i (.addr(req.addr), .rdata(periph_rdata));
    task automatic chk(string n, logic [15:0] e, g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    // One access, held for one edge; outputs sampled once they settle
    task automatic acc(logic w, b, logic [7:0] a, d, logic i = 0, e = 0);
        @(posedge clk);
        req <= '{1'b1, w, b, 3'h0, a, d};
        indirect <= i;
        instr_done <= e;
        @(posedge clk);
        req.valid <= 1'b0;
        instr_done <= 1'b0;
        #1;
    endtask
    task automatic mv(logic s, logic [7:0] ix, logic [15:0] dp, ex);
        @(posedge clk);
        xmove_short <= s;
        index_reg <= ix;
        dptr <= dp;
        @(posedge clk);
        #1;
        chk("xram_addr", ex, xram_addr);
    endtask
    // Only occupied locations are used; page 0xf entered and left in order
    task automatic t_page;
        chk("reset page", 8'h00, page_select_q);
        acc(1, 0, 8'ha7, 8'h0f, 0, 1);
        acc(0, 0, 8'ha7, 8'h00);
        chk("page read", 8'h0f, rdata);
        acc(0, 0, 8'h91, 8'h00);
        chk("paged", 8'h0f, periph_page);
        chk("periph addr", 8'h91, periph_addr);
        chk("periph sel", 1, periph_sel);
        acc(0, 0, 8'he0, 8'h00);
        chk("shared", 8'h00, periph_page);
        acc(0, 0, 8'haa, 8'h00);
        chk("off page", 8'h55, rdata);
        chk("off page sel", 1, periph_sel);
        acc(1, 0, 8'ha7, 8'h00, 0, 1);
        acc(1, 0, 8'ha7, 8'h0f);
        chk("pending", 8'h00, page_select_q);
        acc(0, 0, 8'h80, 8'h00, 0, 1);
        chk("applied", 8'h0f, page_select_q);
        acc(1, 0, 8'ha7, 8'h00, 0, 1);
    endtask
    task automatic t_xram;
        acc(1, 0, 8'haa, 8'hf3);
        acc(0, 0, 8'haa, 8'h00);
        chk("xram page", 8'h03, rdata);
        chk("xram local", 0, periph_sel);
        mv(1, 8'h34, 16'hffff, 16'h0334);
        mv(0, 8'h34, 16'h1234, 16'h1234);
    endtask
    task automatic t_bit;
        acc(1, 1, 8'h81, 8'h01);
        chk("refused", 1, bit_refused);
        chk("refused sel", 0, periph_sel);
        acc(1, 1, 8'h88, 8'h01);
        chk("accepted", 0, bit_refused);
        chk("accepted sel", 1, periph_sel);
    endtask
    task automatic t_hit;
        acc(0, 0, 8'h90, 8'h00, 1);
        chk("indirect", 0, sfr_hit);
        acc(0, 0, 8'h90, 8'h00);
        chk("direct", 1, sfr_hit);
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        t_page;
        t_xram;
        t_bit;
        t_hit;
        end_of_test;
    end
    // Hang guard
    initial begin
        repeat (2000) @(posedge clk);
        miscompares++;
        end_of_test;
    end
endmodule
